// File: wcrc_defines.vh
// Purpose: constants for the write checksum frame checker
// Assumes: apb with 32-bit data, word aligned registers
// Notes:   definitions only
`ifndef WCRC_DEFINES_VH
`define WCRC_DEFINES_VH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CONTROL   8'h00
`define OFS_STATUS    8'h04
`define OFS_CHECKSUM  8'h08

// ==========================================================
// control fields
`define CTL_CRC_EN    0
`define CTL_WIDTH_LO  1
`define CTL_WIDTH_HI  2
`define CTL_MASK_EN   3
`define CONTROL_RST   4'h0

// ==========================================================
// status fields
`define STS_CRC_ERR   0
`define STS_FRAME_ERR 1
`define STS_BUSY      2
`define STS_CNT_LO    8
`define STS_CNT_HI    15

// ==========================================================
// width modes
`define WIDTH_X4      2'h0
`define WIDTH_X8      2'h1
`define WIDTH_X16     2'h2

// ==========================================================
// frame shape
`define BEATS         4'ha
`define LAST_BEAT     4'h9
`define CRC_BEAT      4'h8
`define LANES         18
`define LINK_BITS     22
`define CRC_INIT      8'h00
`define CRC_POLY      8'h07

`endif

// File: write_crc_frame_mapping.v
// Purpose: device side write checksum check for x4, x8, x16 frames
// Assumes: link pins are asynchronous and sampled by clk_i
// Notes:   each strobe edge (both directions) carries one beat
//
// Functional notes
// - x4 eight-beat: data, then checksum nibbles
// - x8 eight-beat: lane n beat t is bit 8n+t
// - beat 8 mask lanes carry constant one
// - x16 uses two independent byte checkers
// - low byte checks 71:0, high 143:72
// - half select bit picks first half
// - x4 chopped: sixteen data bits, rest ones
// - chopped beats 4-7 ones, checksum unchanged
// - upper half feeds lower generator positions
// - x8 chopped: thirty-two data, four mask bits
// - half zero: mask into 67:64 or ones
// - half one: mask into 71:68 or ones
// - x16 chopped: two thirty-six input generators
// - upper byte mask into 139:136 or 143:140
// - x4 chopped half one: upper bits first
// - generator polynomial x8+x2+x+1
// - zero start, bit 71 first
// - recompute, compare, flag on alert
`timescale 1ns/1ps
`include "wcrc_defines.vh"

module write_crc_frame_mapping (
   // clock and reset
   input  wire        clk_i,
   input  wire        sys_rst_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // write link pins
   input  wire        write_strobe_i,
   input  wire        write_cmd_i,
   input  wire        chopped_four_beat_burst_i,
   input  wire        critical_half_select_bit_i,
   input  wire [15:0] dq_i,
   input  wire        lower_byte_mask_invert_lane_i,
   input  wire        upper_byte_mask_invert_lane_i,
   // error report
   output reg         alert_n_o
);

   // =======================================================
   // states
   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_COLLECT = 2'h1;
   localparam [1:0] ST_CHECK   = 2'h2;

   // =======================================================
   // declarations
   reg  [`LINK_BITS-1:0] link_s1;
   reg  [`LINK_BITS-1:0] link_s2;
   reg                   strobe_q;
   reg                   cmd_q;
   reg  [3:0]            control;
   reg                   crc_err;
   reg                   frame_err;
   reg  [7:0]            err_cnt;
   reg  [7:0]            rx_lo_q;
   reg  [7:0]            calc_lo_q;
   reg  [7:0]            rx_hi_q;
   reg  [7:0]            calc_hi_q;
   reg  [1:0]            state;
   reg  [3:0]            beat_idx;
   reg                   chop;
   reg                   half;
   reg  [1:0]            width;
   reg                   mask_en;
   reg  [17:0]           beat_mem [0:9];
   reg  [71:0]           word_lo;
   reg  [71:0]           word_hi;
   reg  [7:0]            rx_lo;
   reg  [7:0]            rx_hi;
   reg  [17:0]           used;
   reg                   bad_frame;
   reg  [31:0]           next_rdata;
   reg                   next_slverr;
   wire [7:0]            calc_lo;
   wire [7:0]            calc_hi;
   wire                  mismatch;
   wire                  strobe_edge;
   wire                  cmd_start;
   wire                  apb_access;
   wire                  apb_wr;
   wire                  clr_crc;
   wire                  clr_frame;
   wire                  set_crc;
   wire                  set_frame;
   integer               n;
   integer               t;
   integer               k;
   integer               r;

   // =======================================================
   // serial checksum, msb of the word shifted in first
   function [7:0] crc8_72;
      input [71:0] d;
      integer      i;
      reg   [7:0]  c;
      reg          fb;
      begin
         c = `CRC_INIT;
         for (i = 71; i >= 0; i = i - 1) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ ({8{fb}} & `CRC_POLY);
         end
         crc8_72 = c;
      end
   endfunction

   // =======================================================
   // pin synchroniser
   // data and strobe share one delay so beats stay aligned
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_s1  <= {`LINK_BITS{1'b0}};
         link_s2  <= {`LINK_BITS{1'b0}};
         strobe_q <= 1'b0;
         cmd_q    <= 1'b0;
      end else begin
         link_s1  <= {upper_byte_mask_invert_lane_i,
                      lower_byte_mask_invert_lane_i, dq_i,
                      critical_half_select_bit_i,
                      chopped_four_beat_burst_i,
                      write_cmd_i, write_strobe_i};
         link_s2  <= link_s1;
         strobe_q <= link_s2[0];
         cmd_q    <= link_s2[1];
      end
   end

   assign strobe_edge = link_s2[0] ^ strobe_q;
   assign cmd_start   = link_s2[1] & ~cmd_q;

   // =======================================================
   // frame capture
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state    <= ST_IDLE;
         beat_idx <= 4'h0;
         chop     <= 1'b0;
         half     <= 1'b0;
         width    <= `WIDTH_X4;
         mask_en  <= 1'b0;
         for (r = 0; r < 10; r = r + 1) begin
            beat_mem[r] <= {`LANES{1'b0}};
         end
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_start && control[`CTL_CRC_EN]) begin
                  chop     <= link_s2[2];
                  half     <= link_s2[3];
                  width    <= control[`CTL_WIDTH_HI:`CTL_WIDTH_LO];
                  mask_en  <= control[`CTL_MASK_EN];
                  beat_idx <= 4'h0;
                  state    <= ST_COLLECT;
               end
            end
            ST_COLLECT: begin
               if (strobe_edge) begin
                  beat_mem[beat_idx] <= link_s2[21:4];
                  beat_idx <= beat_idx + 4'h1;
                  if (beat_idx == `LAST_BEAT) begin
                     state <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // generator input maps
   // chopped frames keep the four received beats in the low
   // positions; the half bit only moves the mask nibble
   always @* begin
      word_lo = {72{1'b1}};
      word_hi = {72{1'b1}};
      rx_lo   = 8'h00;
      rx_hi   = 8'h00;
      for (n = 0; n < 8; n = n + 1) begin
         for (t = 0; t < 8; t = t + 1) begin
            if (!chop || t < 4) begin
               if (width != `WIDTH_X4 || n < 4) begin
                  word_lo[8*n+t] = beat_mem[t][n];
               end
               word_hi[8*n+t] = beat_mem[t][8+n];
            end
         end
      end
      if (mask_en && width != `WIDTH_X4) begin
         for (t = 0; t < 8; t = t + 1) begin
            if (!chop) begin
               word_lo[64+t] = beat_mem[t][16];
               word_hi[64+t] = beat_mem[t][17];
            end else if (t < 4) begin
               if (half) begin
                  word_lo[68+t] = beat_mem[t][16];
                  word_hi[68+t] = beat_mem[t][17];
               end else begin
                  word_lo[64+t] = beat_mem[t][16];
                  word_hi[64+t] = beat_mem[t][17];
               end
            end
         end
      end
      if (width == `WIDTH_X4) begin
         for (n = 0; n < 4; n = n + 1) begin
            rx_lo[n]   = beat_mem[8][n];
            rx_lo[n+4] = beat_mem[9][n];
         end
      end else begin
         for (n = 0; n < 8; n = n + 1) begin
            rx_lo[n] = beat_mem[8][n];
            rx_hi[n] = beat_mem[8][8+n];
         end
      end
   end

   // =======================================================
   // frame shape check: padding beats must be all ones on the lanes the width uses
   always @* begin
      case (width)
         `WIDTH_X8:  used = 18'h100ff;
         `WIDTH_X16: used = 18'h3ffff;
         default:    used = 18'h0000f;
      endcase
      bad_frame = 1'b0;
      if (chop) begin
         // own index: a shared one makes the comb blocks wake each other
         for (k = 4; k < 8; k = k + 1) begin
            bad_frame = bad_frame | (|(~beat_mem[k] & used));
         end
      end
      if (width != `WIDTH_X4) begin
         bad_frame = bad_frame | (|(~beat_mem[9] & used));
         bad_frame = bad_frame |
                     (|(~beat_mem[8][17:16] & used[17:16]));
      end
   end

   // two identical generators, one per byte group
   assign calc_lo  = crc8_72(word_lo);
   assign calc_hi  = crc8_72(word_hi);
   assign mismatch = (calc_lo != rx_lo) ||
                     (width == `WIDTH_X16 &&
                      calc_hi != rx_hi);

   // =======================================================
   // apb slave, one wait state
   assign apb_access = psel_i & penable_i & ~pready_o;
   assign apb_wr     = apb_access & pwrite_i;
   assign clr_crc    = apb_wr && paddr_i == `OFS_STATUS &&
                       pwdata_i[`STS_CRC_ERR];
   assign clr_frame  = apb_wr && paddr_i == `OFS_STATUS &&
                       pwdata_i[`STS_FRAME_ERR];
   assign set_crc    = (state == ST_CHECK) & mismatch;
   assign set_frame  = (state == ST_CHECK) & bad_frame;

   always @* begin
      next_rdata  = 32'h00000000;
      next_slverr = 1'b0;
      case (paddr_i)
         `OFS_CONTROL: next_rdata = {28'h0000000, control};
         `OFS_STATUS: begin
            next_rdata[`STS_CRC_ERR]   = crc_err;
            next_rdata[`STS_FRAME_ERR] = frame_err;
            next_rdata[`STS_BUSY]      = (state != ST_IDLE);
            next_rdata[`STS_CNT_HI:`STS_CNT_LO] = err_cnt;
         end
         `OFS_CHECKSUM: begin
            next_rdata = {calc_hi_q, rx_hi_q, calc_lo_q, rx_lo_q};
         end
         default: next_slverr = 1'b1;
      endcase
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
         control   <= `CONTROL_RST;
      end else begin
         pready_o  <= apb_access;
         pslverr_o <= apb_access & next_slverr;
         if (apb_access && !pwrite_i) begin
            prdata_o <= next_rdata;
         end
         if (apb_wr && paddr_i == `OFS_CONTROL) begin
            control <= pwdata_i[3:0];
         end
      end
   end

   // =======================================================
   // error status; a new error beats a clear in the same cycle
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         crc_err   <= 1'b0;
         frame_err <= 1'b0;
         err_cnt   <= 8'h00;
         rx_lo_q   <= 8'h00;
         rx_hi_q   <= 8'h00;
         calc_lo_q <= 8'h00;
         calc_hi_q <= 8'h00;
         alert_n_o <= 1'b1;
      end else begin
         crc_err   <= set_crc | (crc_err & ~clr_crc);
         frame_err <= set_frame | (frame_err & ~clr_frame);
         alert_n_o <= ~(set_crc | (crc_err & ~clr_crc));
         if (set_crc && err_cnt != 8'hff) begin
            err_cnt <= err_cnt + 8'h01;
         end
         if (state == ST_CHECK) begin
            rx_lo_q   <= rx_lo;
            rx_hi_q   <= rx_hi;
            calc_lo_q <= calc_lo;
            calc_hi_q <= calc_hi;
         end
      end
   end

endmodule // write_crc_frame_mapping

// File: write_crc_frame_mapping_assertions.sv
// Purpose: port checks for the write checksum frame checker
// Assumes: one wait state on apb, registered alert
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
module wcrc_checker (
   // clock, reset, apb, link
   input wire        clk_i,
   input wire        sys_rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        write_strobe_i,
   input wire        alert_n_o
);
   // ======================================================
   // helpers
   reg       sq;
   reg [3:0] quiet;
   wire      acc = psel_i && penable_i;
   wire      clr = acc && !pready_o && pwrite_i && paddr_i == 8'h04
                   && pwdata_i[0];
   // strobe is asynchronous: count clocks since its last edge
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sq    <= 1'b0;
         quiet <= 4'hf;
      end else begin
         sq    <= write_strobe_i;
         quiet <= sq != write_strobe_i ? 4'h0
                  : quiet + {3'h0, quiet != 4'hf};
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence taken_s;
      acc && !pready_o;
   endsequence
   sequence ready_s;
      pready_o ##1 !pready_o;
   endsequence
   wait_state_a: assert property (taken_s |=> ready_s)
      else $error("no one cycle answer");
   ready_cause_a: assert property (pready_o |-> $past(acc))
      else $error("answer without access");
   err_qual_a: assert property (pslverr_o |-> pready_o)
      else $error("error outside answer");
   bad_read_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 0)
      else $error("refused read gave data");
   unmapped_a: assert property (taken_s ##0 paddr_i > 8'h08 |=> pslverr_o)
      else $error("unmapped not refused");
   mapped_ok_a: assert property (taken_s ##0 paddr_i == 8'h04 |=> !pslverr_o)
      else $error("mapped word refused");
   alert_clear_a: assert property (
      $rose(alert_n_o) |-> $past(clr) || $past(clr, 2))
      else $error("alert rose without clear");
   alert_cause_a: assert property (
      $fell(alert_n_o) |-> quiet < 4'ha)
      else $error("alert fell away from a frame");
endmodule // wcrc_checker

bind write_crc_frame_mapping wcrc_checker wcrc_checker_i (.clk_i,
   .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .prdata_o, .pready_o, .pslverr_o, .write_strobe_i, .alert_n_o);

// File: crc_write_host.sv
// Purpose: controller model that builds checksum write frames
// Assumes: one beat per strobe edge, 32 ns apart
// Notes:   f corrupts the sent checksum, p lane 0 of beat 5 (chopped) or beat 9, on purpose
`timescale 1ns/1ps
module crc_write_host (
   // link outputs
   output reg        write_cmd_o,
   output reg        strobe_o,
   output reg        chop_o,
   output reg        half_o,
   output reg [15:0] dq_o,
   output reg        lo_mask_o,
   output reg        hi_mask_o
);
   reg [71:0] wl, wh;
   reg [7:0]  cl, ch;
   reg [1:0]  cw;
   reg        mm;
   integer    t, n;
   initial begin
      {write_cmd_o, strobe_o, chop_o, half_o} = 4'h0;
      {dq_o, lo_mask_o, hi_mask_o} = 18'h0;
   end
   // ======================================================
   // generator, serial form
   function [7:0] crc8(input [71:0] w);
      integer i;
      begin
         crc8 = 8'h00;
         for (i = 71; i >= 0; i--)
            crc8 = {crc8[6:0], 1'b0} ^ (crc8[7] ^ w[i] ? 8'h07 : 8'h00);
      end
   endfunction
   function [71:0] fill(input [71:0] w);
      begin
         fill = w;
         if (cw == 2'h0 || !mm)
            fill[71:64] = 8'hff;
         if (cw == 2'h0)
            fill[63:32] = 32'hffffffff;
         for (n = 0; n < 8 && chop_o; n++)
            fill[8 * n +: 8] = {4'hf, fill[8 * n + 4 * half_o +: 4]};
         if (chop_o)
            fill[(half_o ? 64 : 68) +: 4] = 4'hf;
      end
   endfunction
   function lane(input [71:0] w, input [7:0] c, input integer k);
      lane = t < 4 || t < 8 && !chop_o ? w[8 * k + t]
           : t < 8 ? 1'b1 : t == 8 ? c[k]
           : cw == 2'h0 ? c[(k + 4) % 8] : 1'b1;
   endfunction
   function mlane(input [71:0] w);
      mlane = t > 7 || chop_o && t > 3 ? 1'b1
            : w[64 + t + (chop_o && half_o ? 4 : 0)];
   endfunction
   // ======================================================
   // one frame
   task send(input [143:0] d, input [1:0] w, input c, h, m,
             input [15:0] f, input p);
      begin
         cw = w;
         mm = m;
         chop_o = c;
         half_o = h;
         wl = fill(d[71:0]);
         wh = fill(d[143:72]);
         cl = crc8(wl) ^ f[7:0];
         ch = crc8(wh) ^ f[15:8];
         write_cmd_o = 1'b1;
         #20;
         for (t = 0; t < 10; t++) begin
            for (n = 0; n < 8; n++) begin
               dq_o[n] = lane(wl, cl, n);
               dq_o[n + 8] = lane(wh, ch, n);
            end
            lo_mask_o = mlane(wl);
            hi_mask_o = mlane(wh);
            if (p && t == (c ? 5 : 9))
               dq_o[0] = ~dq_o[0];
            #16 strobe_o = ~strobe_o;
            #16;
         end
         write_cmd_o = 1'b0;
         // released lanes never keep the stale value
         {dq_o, lo_mask_o, hi_mask_o} = ~{dq_o, lo_mask_o, hi_mask_o};
      end
   endtask
endmodule // crc_write_host

// File: write_crc_frame_mapping_tb.sv
// Purpose: self-checking bench for the write checksum frame checker
// Assumes: one wait state on apb, alert a few clocks after beat 9
// Notes:   the controller model builds every frame
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
   $display("unexpected %0t got %h exp %h", $time, a, e); end end
module write_crc_frame_mapping_tb;
   // ======================================================
   // signals
   reg         clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, eq;
   reg  [7:0]  paddr_i;
   reg  [31:0] pwdata_i, rq, ex;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, alert_n_o;
   wire        cmd, stb, chop, half, lom, him;
   wire [15:0] dq;
   integer     errors = 0, total_checks = 0, cyc = 0, i;
   write_crc_frame_mapping write_crc_frame_mapping_i (.clk_i, .sys_rst_i,
      .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .write_strobe_i(stb), .write_cmd_i(cmd),
      .chopped_four_beat_burst_i(chop), .critical_half_select_bit_i(half),
      .dq_i(dq), .lower_byte_mask_invert_lane_i(lom),
      .upper_byte_mask_invert_lane_i(him), .alert_n_o);
   crc_write_host crc_write_host_i (.write_cmd_o(cmd), .strobe_o(stb),
      .chop_o(chop), .half_o(half), .dq_o(dq), .lo_mask_o(lom),
      .hi_mask_o(him));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // the whole run needs about 2100 clocks
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish;
      end
   end
   // ======================================================
   // tasks
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         psel_i   <= 1'b1;
         pwrite_i <= w;
         paddr_i  <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1'b1;
         // only the bench timeout ends this wait
         do @(posedge clk_i); while (pready_o !== 1'b1);
         rq = prdata_o;
         eq = pslverr_o;
         psel_i    <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         `CHK(rq, e)
      end
   endtask
   task frame(input [1:0] w, input c, h, m, input [15:0] f,
              input [143:0] d);
      begin
         apb(1'b1, 8'h00, {28'h0, m, w, 1'b1});
         @(posedge clk_i);
         crc_write_host_i.send(d, w, c, h, m, f, 1'b0);
         repeat (12) @(posedge clk_i);
      end
   endtask
   // ======================================================
   // sequence
   initial begin
      {sys_rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
      paddr_i  = 8'h00;
      pwdata_i = 32'h0;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (i = 0; i < 16; i += 4) begin
         rd(8'(i), 32'h0);
         `CHK(eq, i == 12)
      end
      // checking off: a corrupt frame passes unnoticed
      crc_write_host_i.send({9{16'h3c5a}}, 2'h1, 1'b0, 1'b0, 1'b0, 16'hff,
                            1'b0);
      repeat (12) @(posedge clk_i);
      `CHK(alert_n_o, 1'b1)
      for (i = 0; i < 18; i++) begin
         frame(2'(i % 3), i > 5, i > 11, 1'(i / 3), 16'h0,
               {9{16'(i * 16'h0b17 + 16'h3c5a)}});
         `CHK(alert_n_o, 1'b1)
      end
      rd(8'h04, 32'h0);
      frame(2'h2, 1'b1, 1'b1, 1'b1, 16'h0001, {9{16'h5aa5}});
      `CHK(alert_n_o, 1'b0)
      frame(2'h2, 1'b0, 1'b0, 1'b0, 16'h8000, {9{16'h1234}});
      rd(8'h04, 32'h0201);
      ex = {crc_write_host_i.crc8(crc_write_host_i.wh), crc_write_host_i.ch,
            crc_write_host_i.crc8(crc_write_host_i.wl), crc_write_host_i.cl};
      rd(8'h08, ex);
      apb(1'b1, 8'h04, 32'h1);
      repeat (3) @(posedge clk_i);
      `CHK(alert_n_o, 1'b1)
      frame(2'h2, 1'b0, 1'b0, 1'b1, 16'h0101, {9{16'hf00d}});
      frame(2'h0, 1'b1, 1'b1, 1'b0, 16'h0010, {9{16'h0ff0}});
      `CHK(alert_n_o, 1'b0)
      rd(8'h04, 32'h0401);
      // broken padding in a chopped x8 frame: shape error, no alert
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h00, 32'h3);
      @(posedge clk_i);
      crc_write_host_i.send({9{16'h6b6b}}, 2'h1, 1'b1, 1'b0, 1'b0, 16'h0,
                            1'b1);
      repeat (12) @(posedge clk_i);
      `CHK(alert_n_o, 1'b1)
      rd(8'h04, 32'h0402);
      tally_and_finish;
   end
endmodule // write_crc_frame_mapping_tb
